// ---- rtl/lcc_params.svh ----
/*
  Constants of the cursor and layer control block: command codes,
  parameter bit positions, step codes, composition codes, reset values.
  Assumes it is included by its bare name in the design and bench files.
*/
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// Command codes
`define LCC_CMD_FORM 8'h5d
`define LCC_CMD_DIR_TOP 6'h13
`define LCC_CMD_LAYER_OVERLAY_CMD 8'h5b
`define LCC_CMD_HDOT 8'h5a
`define LCC_CMD_CURSOR_ADDR_WRITE_CMD 8'h46
`define LCC_CMD_CURSOR_ADDR_READ_CMD 8'h47
`define LCC_CMD_MEMORY_WRITE_CMD 8'h42
`define LCC_CMD_MEMORY_READ_CMD 8'h43

// Step direction codes (low two bits of the direction command)
`define LCC_DIR_RIGHT 2'h0
`define LCC_DIR_LEFT 2'h1
`define LCC_DIR_UP 2'h2
`define LCC_DIR_DOWN 2'h3

// Composition codes
`define LCC_MX_OR 2'h0
`define LCC_MX_XOR 2'h1
`define LCC_MX_AND 2'h2
`define LCC_MX_PRI 2'h3

// Parameter bit positions
`define LCC_CM_BIT 7
`define LCC_MX_LO 0
`define LCC_MX_HI 1
`define LCC_DM1_BIT 2
`define LCC_DM2_BIT 3
`define LCC_OV_BIT 4

// Reset values
`define LCC_RST_WIDTH 5'h01
`define LCC_RST_LINES 5'h08
`define LCC_RST_CURSOR 16'h0000

`endif

// ---- rtl/lcc_pkg.sv ----
/*
  Types of the cursor and layer control block.
  Assumes nothing of its surroundings.
*/
package lcc_pkg;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_FORM = 8'h02,
        ST_LAYER_OVERLAY_CMD = 8'h04,
        ST_HDOT = 8'h08,
        ST_CURSOR_ADDR_WRITE_CMD = 8'h10,
        ST_CURSOR_ADDR_READ_CMD = 8'h20,
        ST_MEMORY_WRITE_CMD = 8'h40,
        ST_MEMORY_READ_CMD = 8'h80
    } lcc_mode_type;

endpackage : lcc_pkg

// ---- rtl/lcc_layer_if.sv ----
/*
  Interface carrying one pixel of each layer, its flash visibility and the
  composition setup from the core to the composer, and the result back.
  Assumes one driver per side: core modport and compose modport.
*/
`timescale 1ns/1ps

interface lcc_layer_if;
    logic l1;
    logic l2;
    logic l3;
    logic v1;
    logic v2;
    logic v3;
    logic [1:0] sel;
    logic use_l3;
    logic pix;

    modport core (output l1, l2, l3, v1, v2, v3, sel, use_l3, input pix);
    modport comp (input l1, l2, l3, v1, v2, v3, sel, use_l3, output pix);
endinterface : lcc_layer_if

// ---- rtl/lcc_compose.sv ----
/*
  Layer composer: combines the three layer pixels by the selected method.
  Assumes the core gates the third layer off through use_l3 when unused.
*/
`timescale 1ns/1ps
`include "lcc_params.svh"

module lcc_compose (
    lcc_layer_if.comp lyr // Layer pixels in, composed pixel out
);

    logic a1;
    logic a2;
    logic a3;

    always_comb begin
        // A layer in its flash-off phase contributes nothing
        a1 = lyr.l1 & lyr.v1;
        a2 = lyr.l2 & lyr.v2;
        a3 = lyr.l3 & lyr.v3 & lyr.use_l3;
        unique case (lyr.sel)
            `LCC_MX_OR: lyr.pix = a1 | a2 | a3;
            `LCC_MX_XOR: lyr.pix = (a1 ^ a2) | a3;
            `LCC_MX_AND: lyr.pix = (a1 & a2) | a3;
            // Upper layer in flash-off also hides the layers under it
            `LCC_MX_PRI: lyr.pix = a1 | (lyr.v1 & (a2 | (lyr.v2 & a3)));
        endcase
    end

endmodule : lcc_compose

// ---- rtl/lcc_core.sv ----
/*
  Command interpreter for cursor form, step direction, layer overlay,
  pixel scroll and the cursor address register of a dot-matrix LCD
  controller, plus the layer composer instance.
  Assumes bus cycle decoding happens upstream on the same clock and
  delivers one-cycle strobes for command, parameter/data write and read.
*/
`timescale 1ns/1ps
`include "lcc_params.svh"

// How it works
// - With dual-screen on, blank each block's line gap to half frame plus one.
// - Cursor width code plus one gives width of 1 to 16 pixels.
// - Cursor height code plus one gives lines; host never writes zero.
// - Shape bit 0 gives underscore cursor, 1 gives block cursor.
// - Direction command codes pick right, left, up or down step.
// - Cursor steps by the selected amount after every memory read or write.
// - Two select bits pick OR, XOR-then-OR, AND-then-OR or priority-OR.
// - One composition method applies to a whole layer.
// - Only layer one holds text; layer three unused when it does.
// - Block one and three mode bits select text or graphics; two, four graphics.
// - Layer count bit picks two or three layer composition.
// - Pixel scroll takes three bits, 0 to 7, for the whole screen.
// - A 16-bit cursor register addresses display memory for reads and writes.
// - Only address write and auto step change the cursor register.
// - Address read returns low byte then high byte on two reads.
// - Dual-screen select enables the fourth block start address.
// - Each written data byte steps the cursor, no further command needed.
module lcc_core (
    input logic CLK, // System clock, 40 MHz
    input logic NRST, // Synchronous reset, active low
    input logic CMD_STB, // Command byte strobe
    input logic [7:0] CMD_CODE, // Command byte
    input logic PRM_STB, // Parameter or display data write strobe
    input logic [7:0] PRM_DATA, // Parameter or display data byte
    input logic RD_STB, // Data read strobe, taken when host reads RD_DATA
    input logic [7:0] MEM_RDATA, // Display memory data, valid while MEM_RD
    input logic [7:0] ADDR_PITCH, // Address pitch in bytes
    input logic DUAL_SCREEN, // Two-screen drive select
    input logic [7:0] FRAME_LINES, // Frame line count setting
    input logic [7:0] BLOCK1_LINES, // First block line count setting
    input logic [7:0] BLOCK2_LINES, // Second block line count setting
    input logic LAYER1_PIX, // Layer one pixel
    input logic LAYER2_PIX, // Layer two pixel
    input logic LAYER3_PIX, // Layer three pixel
    input logic LAYER1_SHOW, // Layer one flash phase visible
    input logic LAYER2_SHOW, // Layer two flash phase visible
    input logic LAYER3_SHOW, // Layer three flash phase visible
    output logic [7:0] RD_DATA, // Read data to host
    output logic [15:0] MEM_ADDR, // Display memory address
    output logic MEM_WR, // Display memory write pulse
    output logic [7:0] MEM_WDATA, // Display memory write data
    output logic MEM_RD, // Display memory read pulse
    output logic [4:0] CURSOR_WIDTH, // Cursor width in pixels
    output logic [4:0] CURSOR_LINES, // Cursor height or underscore line
    output logic CURSOR_BLOCK, // Block cursor when high
    output logic [1:0] STEP_DIR, // Auto step direction code
    output logic [1:0] COMPOSE_SEL, // Composition method code
    output logic BLOCK1_GFX, // Block one graphics when high
    output logic BLOCK3_GFX, // Block three graphics when high
    output logic BLOCK24_GFX, // Blocks two and four, always graphics
    output logic THREE_LAYER, // Three-layer composition when high
    output logic LAYER3_USED, // Layer three takes part in composition
    output logic [2:0] SCROLL_PIX, // Horizontal pixel scroll
    output logic BLOCK4_EN, // Fourth block start address enabled
    output logic [7:0] BLANK1_LINES, // Lines blanked for block one
    output logic [7:0] BLANK2_LINES, // Lines blanked for block two
    output logic PIX_OUT // Composed pixel
);

    lcc_pkg::lcc_mode_type mode;
    logic prm_idx;
    logic [7:0] addr_lo;
    logic [15:0] cursor;
    logic [15:0] next_cursor;
    logic [15:0] pitch;
    logic prm_ok;
    logic form_prm;
    logic cursor_addr_write_cmd_prm;
    logic data_wr;
    logic fetch;
    logic [8:0] half_lines;

    lcc_layer_if lyr ();

    function automatic logic [7:0] gap(input logic [8:0] a, input logic [8:0] b);
        logic [8:0] d;
        d = (a >= b) ? a - b : b - a;
        return d[7:0];
    endfunction : gap

    // A command in the same cycle outranks a parameter or read
    assign prm_ok = PRM_STB && !CMD_STB;
    assign form_prm = prm_ok && mode == lcc_pkg::ST_FORM;
    assign cursor_addr_write_cmd_prm = prm_ok && mode == lcc_pkg::ST_CURSOR_ADDR_WRITE_CMD;
    assign data_wr = prm_ok && mode == lcc_pkg::ST_MEMORY_WRITE_CMD;
    // Each fetch uses the current address, then the cursor steps
    assign fetch = (RD_STB && !CMD_STB && mode == lcc_pkg::ST_MEMORY_READ_CMD)
        || (CMD_STB && CMD_CODE == `LCC_CMD_MEMORY_READ_CMD);
    assign pitch = {8'h00, ADDR_PITCH};
    assign half_lines = ({1'b0, FRAME_LINES} + 9'h001) >> 1;
    assign BLOCK24_GFX = 1'b1;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            mode <= lcc_pkg::ST_IDLE;
            prm_idx <= 1'b0;
        end else if (CMD_STB) begin
            prm_idx <= 1'b0;
            case (CMD_CODE)
                `LCC_CMD_FORM: mode <= lcc_pkg::ST_FORM;
                `LCC_CMD_LAYER_OVERLAY_CMD: mode <= lcc_pkg::ST_LAYER_OVERLAY_CMD;
                `LCC_CMD_HDOT: mode <= lcc_pkg::ST_HDOT;
                `LCC_CMD_CURSOR_ADDR_WRITE_CMD: mode <= lcc_pkg::ST_CURSOR_ADDR_WRITE_CMD;
                `LCC_CMD_CURSOR_ADDR_READ_CMD: mode <= lcc_pkg::ST_CURSOR_ADDR_READ_CMD;
                `LCC_CMD_MEMORY_WRITE_CMD: mode <= lcc_pkg::ST_MEMORY_WRITE_CMD;
                `LCC_CMD_MEMORY_READ_CMD: mode <= lcc_pkg::ST_MEMORY_READ_CMD;
                default: mode <= lcc_pkg::ST_IDLE;
            endcase
        end else if (prm_ok && (mode == lcc_pkg::ST_FORM || mode == lcc_pkg::ST_CURSOR_ADDR_WRITE_CMD)) begin
            prm_idx <= ~prm_idx;
            if (prm_idx) begin
                mode <= lcc_pkg::ST_IDLE;
            end
        end else if (prm_ok && (mode == lcc_pkg::ST_LAYER_OVERLAY_CMD || mode == lcc_pkg::ST_HDOT)) begin
            mode <= lcc_pkg::ST_IDLE;
        end else if (RD_STB && mode == lcc_pkg::ST_CURSOR_ADDR_READ_CMD) begin
            prm_idx <= ~prm_idx;
            if (prm_idx) begin
                mode <= lcc_pkg::ST_IDLE;
            end
        end
    end

    // Cursor form
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            CURSOR_WIDTH <= `LCC_RST_WIDTH;
            CURSOR_LINES <= `LCC_RST_LINES;
            CURSOR_BLOCK <= 1'b0;
        end else if (form_prm && !prm_idx) begin
            CURSOR_WIDTH <= {1'b0, PRM_DATA[3:0]} + 5'h01;
        end else if (form_prm) begin
            CURSOR_LINES <= {1'b0, PRM_DATA[3:0]} + 5'h01;
            CURSOR_BLOCK <= PRM_DATA[`LCC_CM_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            STEP_DIR <= `LCC_DIR_RIGHT;
        end else if (CMD_STB && CMD_CODE[7:2] == `LCC_CMD_DIR_TOP) begin
            STEP_DIR <= CMD_CODE[1:0];
        end
    end

    // Overlay setup: one method for every block that shares a layer
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            COMPOSE_SEL <= `LCC_MX_OR;
            BLOCK1_GFX <= 1'b0;
            BLOCK3_GFX <= 1'b0;
            THREE_LAYER <= 1'b0;
            LAYER3_USED <= 1'b0;
        end else if (prm_ok && mode == lcc_pkg::ST_LAYER_OVERLAY_CMD) begin
            COMPOSE_SEL <= {PRM_DATA[`LCC_MX_HI], PRM_DATA[`LCC_MX_LO]};
            BLOCK1_GFX <= PRM_DATA[`LCC_DM1_BIT];
            BLOCK3_GFX <= PRM_DATA[`LCC_DM2_BIT];
            THREE_LAYER <= PRM_DATA[`LCC_OV_BIT];
            LAYER3_USED <= PRM_DATA[`LCC_DM1_BIT] & PRM_DATA[`LCC_OV_BIT];
        end
    end

    // Scroll is screen wide and never touches the cursor
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            SCROLL_PIX <= 3'h0;
        end else if (prm_ok && mode == lcc_pkg::ST_HDOT) begin
            SCROLL_PIX <= PRM_DATA[2:0];
        end
    end

    always_comb begin
        unique case (STEP_DIR)
            `LCC_DIR_RIGHT: next_cursor = cursor + 16'h0001;
            `LCC_DIR_LEFT: next_cursor = cursor - 16'h0001;
            `LCC_DIR_UP: next_cursor = cursor - pitch;
            `LCC_DIR_DOWN: next_cursor = cursor + pitch;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cursor <= `LCC_RST_CURSOR;
            addr_lo <= 8'h00;
        end else if (cursor_addr_write_cmd_prm && !prm_idx) begin
            addr_lo <= PRM_DATA;
        end else if (cursor_addr_write_cmd_prm) begin
            cursor <= {PRM_DATA, addr_lo};
        end else if (data_wr || fetch) begin
            cursor <= next_cursor;
        end
    end

    // Memory strobes lag one cycle, so MEM_ADDR shows the pre-step address
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            MEM_ADDR <= `LCC_RST_CURSOR;
            MEM_WR <= 1'b0;
            MEM_RD <= 1'b0;
            MEM_WDATA <= 8'h00;
        end else begin
            MEM_ADDR <= cursor;
            MEM_WR <= data_wr;
            MEM_RD <= fetch;
            if (data_wr) begin
                MEM_WDATA <= PRM_DATA;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RD_DATA <= 8'h00;
        end else if (CMD_STB && CMD_CODE == `LCC_CMD_CURSOR_ADDR_READ_CMD) begin
            RD_DATA <= cursor[7:0];
        end else if (RD_STB && !CMD_STB && mode == lcc_pkg::ST_CURSOR_ADDR_READ_CMD && !prm_idx) begin
            RD_DATA <= cursor[15:8];
        end else if (MEM_RD) begin
            RD_DATA <= MEM_RDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            BLOCK4_EN <= 1'b0;
            BLANK1_LINES <= 8'h00;
            BLANK2_LINES <= 8'h00;
        end else begin
            BLOCK4_EN <= DUAL_SCREEN;
            BLANK1_LINES <= DUAL_SCREEN ? gap({1'b0, BLOCK1_LINES}, half_lines) : 8'h00;
            BLANK2_LINES <= DUAL_SCREEN ? gap({1'b0, BLOCK2_LINES}, half_lines) : 8'h00;
        end
    end

    assign lyr.l1 = LAYER1_PIX;
    assign lyr.l2 = LAYER2_PIX;
    assign lyr.l3 = LAYER3_PIX;
    assign lyr.v1 = LAYER1_SHOW;
    assign lyr.v2 = LAYER2_SHOW;
    assign lyr.v3 = LAYER3_SHOW;
    assign lyr.sel = COMPOSE_SEL;
    assign lyr.use_l3 = LAYER3_USED;

    lcc_compose u_compose (
        .lyr(lyr)
    );

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PIX_OUT <= 1'b0;
        end else begin
            PIX_OUT <= lyr.pix;
        end
    end

    blank_off_a: assert property (@(posedge CLK) disable iff (!NRST)
        !DUAL_SCREEN |=> BLANK1_LINES == 8'h00 && BLANK2_LINES == 8'h00)
        else $error("blanking active without dual screen");

    cursor_width_a: assert property (@(posedge CLK) disable iff (!NRST)
        form_prm && !prm_idx |=> CURSOR_WIDTH == {1'b0, $past(PRM_DATA[3:0])} + 5'h01)
        else $error("cursor width not code plus one");

    cursor_lines_a: assert property (@(posedge CLK) disable iff (!NRST)
        form_prm && prm_idx |=> CURSOR_LINES == {1'b0, $past(PRM_DATA[3:0])} + 5'h01)
        else $error("cursor lines not code plus one");

    cursor_shape_a: assert property (@(posedge CLK) disable iff (!NRST)
        form_prm && prm_idx |=> CURSOR_BLOCK == $past(PRM_DATA[7]) && $stable(CURSOR_WIDTH))
        else $error("cursor shape not taken");

    step_cmd_a: assert property (@(posedge CLK) disable iff (!NRST)
        CMD_STB && CMD_CODE[7:2] == `LCC_CMD_DIR_TOP |=> STEP_DIR == $past(CMD_CODE[1:0]))
        else $error("step direction not taken");

    write_step_a: assert property (@(posedge CLK) disable iff (!NRST)
        data_wr && STEP_DIR == `LCC_DIR_DOWN |=> cursor == $past(cursor) + $past(pitch) && MEM_WR)
        else $error("write did not step cursor by pitch");

    write_addr_a: assert property (@(posedge CLK) disable iff (!NRST)
        data_wr |=> MEM_WR && MEM_ADDR == $past(cursor) && MEM_WDATA == $past(PRM_DATA))
        else $error("memory write address or data wrong");

    cursor_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
        !PRM_STB && !fetch |=> $stable(cursor))
        else $error("cursor changed without cause");

    cursor_addr_write_cmd_load_a: assert property (@(posedge CLK) disable iff (!NRST)
        cursor_addr_write_cmd_prm ##1 cursor_addr_write_cmd_prm |=> cursor == {$past(PRM_DATA), $past(PRM_DATA, 2)})
        else $error("cursor address write wrong");

    addr_read_a: assert property (@(posedge CLK) disable iff (!NRST)
        RD_STB && !CMD_STB && mode == lcc_pkg::ST_CURSOR_ADDR_READ_CMD && !prm_idx
        |=> RD_DATA == $past(cursor[15:8]) && mode == lcc_pkg::ST_CURSOR_ADDR_READ_CMD)
        else $error("cursor read order wrong");

    layer3_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
        LAYER3_USED |-> BLOCK1_GFX && THREE_LAYER)
        else $error("layer three used with text");

    scroll_take_a: assert property (@(posedge CLK) disable iff (!NRST)
        prm_ok && mode == lcc_pkg::ST_HDOT |=> SCROLL_PIX == $past(PRM_DATA[2:0]) && $stable(cursor))
        else $error("scroll not taken or cursor moved");

endmodule : lcc_core

// ---- testbench/lcc_host.sv ----
/*
  Host processor model: issues command, parameter, data and read strobes.
  Assumes one calling process and the block's clock on clk.
*/
`timescale 1ns/1ps

module lcc_host (
    input wire logic clk, // System clock
    output logic cmd_stb, // Command strobe
    output logic [7:0] cmd_code, // Command byte
    output logic prm_stb, // Parameter or data strobe
    output logic [7:0] prm_data, // Parameter or data byte
    output logic rd_stb // Read strobe
);
    initial begin
        cmd_stb = 1'b0;
        cmd_code = 8'h00;
        prm_stb = 1'b0;
        prm_data = 8'h00;
        rd_stb = 1'b0;
    end

    // Released bytes are inverted so a stale value never passes for a fresh one
    task automatic cmd(input logic [7:0] c);
        @(posedge clk);
        cmd_stb <= 1'b1;
        cmd_code <= c;
        @(posedge clk);
        cmd_stb <= 1'b0;
        cmd_code <= ~c;
        #1;
    endtask : cmd

    // Back-to-back bytes keep the strobe high across the whole burst
    task automatic burst(input logic [7:0] q[$]);
        foreach (q[k]) begin
            @(posedge clk);
            prm_stb <= 1'b1;
            prm_data <= q[k];
        end
        @(posedge clk);
        prm_stb <= 1'b0;
        prm_data <= ~prm_data;
        #1;
    endtask : burst

    task automatic prm(input logic [7:0] b);
        logic [7:0] q[$];
        q = {b};
        burst(q);
    endtask : prm

    task automatic rd();
        @(posedge clk);
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
    endtask : rd

    // Both address bytes go back to back, as a fast host would send them
    task automatic cursor_addr_write_cmd(input logic [15:0] a);
        logic [7:0] q[$];
        cmd(8'h46);
        q = {a[7:0], a[15:8]};
        burst(q);
    endtask : cursor_addr_write_cmd
endmodule : lcc_host

// ---- testbench/lcc_core_test.sv ----
/*
  Self-checking bench of the cursor and layer control core.
  Assumes the host model drives the strobes and memory data follows the address.
*/
`timescale 1ns/1ps
`include "lcc_params.svh"

module lcc_core_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_stb, prm_stb, rd_stb, mem_wr, mem_rd, cursor_block, block1_gfx, block3_gfx, block24_gfx;
    logic three_layer, layer3_used, block4_en, pix_out, dual = 1'b0;
    logic [7:0] cmd_code, prm_data, rd_data, mem_wdata, blank1, blank2;
    logic [7:0] pitch = 8'h28, frame = 8'h00, b1 = 8'h00, b2 = 8'h00;
    logic [15:0] mem_addr, cur;
    logic [4:0] cursor_width, cursor_lines;
    logic [1:0] step_dir, compose_sel;
    logic [2:0] scroll_pix;
    logic [5:0] pv = 6'h00;
    logic [15:0] exp_wa[$], exp_ra[$];
    logic [7:0] exp_wd[$], bytes[$], rd_exp;
    logic rd_pend = 1'b0;
    int n_mismatch = 0, checked = 0, seed;

    always #12.5 clk = ~clk;

    lcc_host host (.clk(clk), .cmd_stb(cmd_stb), .cmd_code(cmd_code), .prm_stb(prm_stb),
        .prm_data(prm_data), .rd_stb(rd_stb));

    lcc_core dut (.CLK(clk), .NRST(nrst), .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .PRM_STB(prm_stb),
        .PRM_DATA(prm_data), .RD_STB(rd_stb), .MEM_RDATA(memf(mem_addr)), .ADDR_PITCH(pitch),
        .DUAL_SCREEN(dual), .FRAME_LINES(frame), .BLOCK1_LINES(b1), .BLOCK2_LINES(b2),
        .LAYER1_PIX(pv[0]), .LAYER2_PIX(pv[1]), .LAYER3_PIX(pv[2]), .LAYER1_SHOW(pv[3]),
        .LAYER2_SHOW(pv[4]), .LAYER3_SHOW(pv[5]), .RD_DATA(rd_data), .MEM_ADDR(mem_addr),
        .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RD(mem_rd), .CURSOR_WIDTH(cursor_width),
        .CURSOR_LINES(cursor_lines), .CURSOR_BLOCK(cursor_block), .STEP_DIR(step_dir),
        .COMPOSE_SEL(compose_sel), .BLOCK1_GFX(block1_gfx), .BLOCK3_GFX(block3_gfx),
        .BLOCK24_GFX(block24_gfx), .THREE_LAYER(three_layer), .LAYER3_USED(layer3_used),
        .SCROLL_PIX(scroll_pix), .BLOCK4_EN(block4_en), .BLANK1_LINES(blank1), .BLANK2_LINES(blank2),
        .PIX_OUT(pix_out));

    function automatic logic [7:0] memf(input logic [15:0] a);
        memf = a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction : memf

    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] d);
        case (d)
            2'h0: step = a + 16'h0001;
            2'h1: step = a - 16'h0001;
            2'h2: step = a - {8'h00, pitch};
            default: step = a + {8'h00, pitch};
        endcase
    endfunction : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // Memory side: every write and fetch must match the model's queue in order
    always @(posedge clk) begin
        if (rd_pend) chk(16'(rd_data), 16'(rd_exp));
        rd_pend = 1'b0;
        if (mem_wr === 1'b1) begin
            if (exp_wa.size() == 0) exp_wa.push_back(~mem_addr);
            if (exp_wd.size() == 0) exp_wd.push_back(~mem_wdata);
            chk(mem_addr, exp_wa.pop_front());
            chk(16'(mem_wdata), 16'(exp_wd.pop_front()));
        end
        if (mem_rd === 1'b1) begin
            if (exp_ra.size() == 0) exp_ra.push_back(~mem_addr);
            rd_exp = memf(exp_ra[0]);
            rd_pend = 1'b1;
            chk(mem_addr, exp_ra.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        logic [3:0] w, h;
        logic [7:0] v;
        logic mx_sh, g, ov, a1, a2, a3, e;
        int half;
        seed = 79847;
        repeat (5) @(posedge clk);
        #1;
        chk({1'b0, cursor_width, cursor_lines, cursor_block, step_dir, compose_sel}, 16'h0500);
        chk({block1_gfx, block3_gfx, block24_gfx, three_layer, layer3_used, scroll_pix}, 16'h0020);
        chk({block4_en, mem_wr, mem_rd, pix_out}, 16'h0000);
        chk(mem_addr | {blank1, blank2} | {rd_data, mem_wdata}, 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            w = (i < 2) ? {4{i[0]}} : 4'($random(seed));
            h = (i < 2) ? {4{~i[0]}} : 4'($random(seed));
            if (h == 4'h0) h = 4'h1;
            mx_sh = 1'($random(seed));
            host.cmd(`LCC_CMD_FORM);
            host.prm({4'h0, w});
            host.prm({mx_sh, 3'h0, h});
            chk(16'(cursor_width), 16'(w) + 16'h0001);
            chk(16'(cursor_lines), 16'(h) + 16'h0001);
            chk(16'(cursor_block), 16'(mx_sh));
        end
        // Graphics runs below use a block cursor as the host must
        host.cmd(`LCC_CMD_FORM);
        host.prm(8'h07);
        host.prm(8'h87);
        for (int d = 0; d < 4; d++) begin
            pitch <= 8'($random(seed));
            host.cmd({`LCC_CMD_DIR_TOP, 2'(d)});
            chk(16'(step_dir), 16'(d));
            cur = (d == 1) ? 16'h0001 : 16'($random(seed));
            host.cursor_addr_write_cmd(cur);
            host.cmd(`LCC_CMD_MEMORY_WRITE_CMD);
            bytes = {};
            for (int k = 0; k < 3; k++) begin
                v = 8'($random(seed));
                bytes.push_back(v);
                exp_wa.push_back(cur);
                exp_wd.push_back(v);
                cur = step(cur, 2'(d));
            end
            host.burst(bytes);
            exp_ra.push_back(cur);
            cur = step(cur, 2'(d));
            host.cmd(`LCC_CMD_MEMORY_READ_CMD);
            repeat (2) begin
                exp_ra.push_back(cur);
                cur = step(cur, 2'(d));
                host.rd();
            end
            // Scroll does not depend on the address pitch, so it needs no preset
            v = 8'($random(seed));
            host.cmd(`LCC_CMD_HDOT);
            host.prm(v);
            chk(16'(scroll_pix), 16'(v[2:0]));
            host.cmd(`LCC_CMD_CURSOR_ADDR_READ_CMD);
            chk(16'(rd_data), 16'(cur[7:0]));
            host.rd();
            chk(16'(rd_data), 16'(cur[15:8]));
            host.rd();
        end
        for (int i = 0; i < 16; i++) begin
            g = i[2];
            ov = i[3] & g;
            host.cmd(`LCC_CMD_LAYER_OVERLAY_CMD);
            host.prm({3'h0, ov, g, g, 2'(i)});
            chk(16'(compose_sel), 16'(i[1:0]));
            chk({11'h0, block1_gfx, block3_gfx, block24_gfx, three_layer, layer3_used},
                {11'h0, g, g, 1'b1, ov, ov});
            repeat (4) begin
                @(posedge clk);
                pv <= 6'($random(seed));
                @(posedge clk);
                #1;
                a1 = pv[0] & pv[3];
                a2 = pv[1] & pv[4];
                a3 = pv[2] & pv[5] & ov;
                case (i[1:0])
                    2'h0: e = a1 | a2 | a3;
                    2'h1: e = (a1 ^ a2) | a3;
                    2'h2: e = (a1 & a2) | a3;
                    default: e = a1 | (pv[3] & (a2 | (pv[4] & a3)));
                endcase
                chk(16'(pix_out), 16'(e));
            end
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            dual <= i[0];
            frame <= (i < 2) ? 8'hff : 8'($random(seed));
            // Start addresses stay upstream; only the line counts reach this block
            b1 <= 8'($random(seed));
            b2 <= 8'($random(seed));
            @(posedge clk);
            @(posedge clk);
            #1;
            half = (int'(frame) + 1) / 2;
            chk(16'(block4_en), 16'(i[0]));
            chk(16'(blank1), i[0] ? 16'((int'(b1) > half) ? int'(b1) - half : half - int'(b1)) : 16'h0);
            chk(16'(blank2), i[0] ? 16'((int'(b2) > half) ? int'(b2) - half : half - int'(b2)) : 16'h0);
        end
        chk(16'(exp_wa.size() + exp_ra.size()), 16'h0000);
        give_verdict();
    end
endmodule : lcc_core_test
